// file: rtl/ddif_top.sv
// Digital input terminal function decode, watchdog and trip logic.
`timescale 1ns/1ps
module ddif_top #(
  parameter int unsigned WD_TICK = ddif_pkg::WD_TICK_CYC,
  parameter int unsigned FILT_TICK = ddif_pkg::FILT_TICK_CYC
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic [7:0] i_multifunction_input_n,
  input wire logic [63:0] i_func_sel,
  input wire logic [6:0] i_input_filter_count,
  input wire logic i_coast_stop_polarity,
  input wire logic i_ext_coast_stop_polarity,
  input wire logic [2:0] i_freq_source_combine_select,
  input wire logic [2:0] i_app_select,
  input wire logic i_pid_active,
  input wire logic i_fire_mode_enable,
  input wire logic i_running,
  input wire logic i_stopped,
  input wire logic i_fault_reset,
  input wire logic [14:0] i_watchdog_timeout_setting,
  input wire logic i_watchdog_stop_select,
  output logic [7:0] o_input_diag_view,
  output logic o_freq_sum_main,
  output logic o_freq_use_secondary,
  output logic o_fire_pressure_setpoint_sel,
  output logic o_fire_mode,
  output logic o_motor_overtemp_fault,
  output logic o_high_freq_mode,
  output logic o_jog_request,
  output logic o_reverse,
  output logic o_watchdog_fault,
  output logic o_wd_coast,
  output logic o_wd_decel,
  output logic o_freq_reset_load,
  output logic o_manual_auto_switch,
  output logic o_manual_run,
  output logic o_auto_run,
  output logic [1:0] o_ramp_set,
  output logic [3:0] o_speed_stage,
  output logic o_coast_stop,
  output logic o_external_trip,
  output logic o_external_fault_indication
);
  typedef enum logic [1:0] {WD_WATCH, WD_DECEL, WD_TRIP} ddif_wd_state_t;

  logic [7:0] func [ddif_pkg::NUM_DI];
  logic [7:0] filt;
  logic [7:0] valid;
  logic [17:0] filt_pre;
  logic [17:0] next_filt_pre;
  logic filt_tick;
  logic next_filt_tick;

  // Sample tick shared by all terminal filters.
  always_comb begin
    next_filt_tick = 1'b0;
    next_filt_pre = filt_pre + 18'h00001;
    if (filt_pre >= 18'(FILT_TICK - 1)) begin
      next_filt_pre = 18'h00000;
      next_filt_tick = 1'b1;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      filt_pre <= 18'h00000;
      filt_tick <= 1'b0;
    end else begin
      filt_pre <= next_filt_pre;
      filt_tick <= next_filt_tick;
    end
  end

  // Polarity is applied after the filter, so a polarity change is seen at once.
  for (genvar g = 0; g < ddif_pkg::NUM_DI; g++) begin : g_di
    assign func[g] = i_func_sel[g*8 +: 8];
    ddif_in_filt u_filt (
      .i_mclk(i_mclk),
      .i_rst(i_rst),
      .i_tick(filt_tick),
      .i_count(i_input_filter_count),
      .i_raw(i_multifunction_input_n[g]),
      .o_level(filt[g])
    );
    assign valid[g] = filt[g] ^ (((func[g] == ddif_pkg::FN_COAST) && !i_coast_stop_polarity) ||
      ((func[g] == ddif_pkg::FN_EXT_TRIP) && !i_ext_coast_stop_polarity));
  end

  function automatic logic fn_on(input logic [7:0] code);
    fn_on = 1'b0;
    for (int k = 0; k < ddif_pkg::NUM_DI; k++) begin
      if (func[k] == code && valid[k]) begin
        fn_on = 1'b1;
      end
    end
  endfunction

  function automatic logic fn_off(input logic [7:0] code);
    fn_off = 1'b0;
    for (int k = 0; k < ddif_pkg::NUM_DI; k++) begin
      if (func[k] == code && !valid[k]) begin
        fn_off = 1'b1;
      end
    end
  endfunction

  logic coast_in;
  logic ext_in;
  logic clear_req;
  logic [3:0] speed_code;
  logic app12;
  logic src_on;
  logic fire_mode_on;
  logic ptc_no_on;
  logic ptc_nc_off;
  logic dir_on;
  logic [1:0] ramp_code;

  always_comb begin
    coast_in = fn_on(ddif_pkg::FN_COAST);
    ext_in = fn_on(ddif_pkg::FN_EXT_TRIP);
    clear_req = i_fault_reset || fn_on(ddif_pkg::FN_RESET);
    speed_code = {fn_on(ddif_pkg::FN_SPEED4), fn_on(ddif_pkg::FN_SPEED3),
      fn_on(ddif_pkg::FN_SPEED2), fn_on(ddif_pkg::FN_SPEED1)};
    src_on = fn_on(ddif_pkg::FN_SRC_SWITCH);
    fire_mode_on = fn_on(ddif_pkg::FN_FIRE_MODE);
    ptc_no_on = fn_on(ddif_pkg::FN_PTC_NO);
    ptc_nc_off = fn_off(ddif_pkg::FN_PTC_NC);
    dir_on = fn_on(ddif_pkg::FN_DIRECTION);
    ramp_code = {fn_on(ddif_pkg::FN_RAMP_HI), fn_on(ddif_pkg::FN_RAMP_LO)};
  end
  assign app12 = (i_app_select == ddif_pkg::APP_1) || (i_app_select == ddif_pkg::APP_2);

  logic [7:0] next_diag;
  logic next_sum;
  logic next_secondary;
  logic next_fire_press;
  logic next_fire_mode;
  logic next_ot;
  logic next_high_freq;
  logic next_jog;
  logic next_reverse;
  logic next_freq_reset;
  logic next_man_auto;
  logic next_manual;
  logic next_auto;
  logic [1:0] next_ramp;
  logic [3:0] next_speed;
  logic next_coast;
  logic next_ext_trip;
  logic next_ext_ind;
  logic ot_set;
  logic ws_coast;

  always_comb begin
    next_diag = valid;
    next_sum = fn_on(ddif_pkg::FN_SRC_SWITCH) &&
      (i_freq_source_combine_select == ddif_pkg::COMBINE_SUM);
    next_secondary = fn_on(ddif_pkg::FN_SRC_SWITCH) &&
      (i_freq_source_combine_select == ddif_pkg::COMBINE_SWAP);
    next_fire_press = i_pid_active && fn_on(ddif_pkg::FN_FIRE_PRESS);
    next_fire_mode = i_fire_mode_enable && fn_on(ddif_pkg::FN_FIRE_MODE);
    ot_set = i_running && (fn_on(ddif_pkg::FN_PTC_NO) ||
      fn_off(ddif_pkg::FN_PTC_NC));
    // A trip arriving with the reset is kept rather than lost.
    next_ot = ot_set || (o_motor_overtemp_fault && !clear_req);
    next_high_freq = fn_on(ddif_pkg::FN_HIGH_FREQ);
    next_reverse = fn_on(ddif_pkg::FN_DIRECTION);
    next_jog = app12 && fn_on(ddif_pkg::FN_JOG) && !coast_in && !ext_in;
    next_freq_reset = (i_app_select == ddif_pkg::APP_4) &&
      fn_on(ddif_pkg::FN_FREQ_RESET);
    next_man_auto = (i_app_select == ddif_pkg::APP_2) && fn_on(ddif_pkg::FN_MAN_AUTO);
    next_manual = next_man_auto && fn_on(ddif_pkg::FN_MANUAL);
    next_auto = next_man_auto && fn_on(ddif_pkg::FN_AUTO) && !next_manual;
    next_ramp = {fn_on(ddif_pkg::FN_RAMP_HI), fn_on(ddif_pkg::FN_RAMP_LO)};
    next_speed = 4'h0;
    if (speed_code != ddif_pkg::SPEED_NONE) begin
      next_speed = speed_code + 4'h1;
    end
    // A watchdog coast is merged here so one output cuts the bridge.
    next_coast = coast_in || ws_coast;
    next_ext_trip = ext_in;
    next_ext_ind = ext_in || (o_external_fault_indication && !clear_req);
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_input_diag_view <= 8'h00;
      o_freq_sum_main <= 1'b0;
      o_freq_use_secondary <= 1'b0;
      o_fire_pressure_setpoint_sel <= 1'b0;
      o_fire_mode <= 1'b0;
      o_motor_overtemp_fault <= 1'b0;
      o_high_freq_mode <= 1'b0;
      o_jog_request <= 1'b0;
      o_reverse <= 1'b0;
      o_freq_reset_load <= 1'b0;
      o_manual_auto_switch <= 1'b0;
      o_manual_run <= 1'b0;
      o_auto_run <= 1'b0;
      o_ramp_set <= 2'h0;
      o_speed_stage <= 4'h0;
      o_coast_stop <= 1'b0;
      o_external_trip <= 1'b0;
      o_external_fault_indication <= 1'b0;
    end else begin
      o_input_diag_view <= next_diag;
      o_freq_sum_main <= next_sum;
      o_freq_use_secondary <= next_secondary;
      o_fire_pressure_setpoint_sel <= next_fire_press;
      o_fire_mode <= next_fire_mode;
      o_motor_overtemp_fault <= next_ot;
      o_high_freq_mode <= next_high_freq;
      o_jog_request <= next_jog;
      o_reverse <= next_reverse;
      o_freq_reset_load <= next_freq_reset;
      o_manual_auto_switch <= next_man_auto;
      o_manual_run <= next_manual;
      o_auto_run <= next_auto;
      o_ramp_set <= next_ramp;
      o_speed_stage <= next_speed;
      o_coast_stop <= next_coast;
      o_external_trip <= next_ext_trip;
      o_external_fault_indication <= next_ext_ind;
    end
  end

  // Watchdog: counts 0.1 s units since the last filtered rising edge.
  ddif_wd_state_t wd_state;
  ddif_wd_state_t next_wd_state;
  logic [24:0] wd_pre;
  logic [24:0] next_wd_pre;
  logic [14:0] wd_cnt;
  logic [14:0] next_wd_cnt;
  logic wd_prev;
  logic wd_level;
  logic wd_edge;
  logic wd_armed;
  logic next_wd_fault;
  logic next_wd_coast;
  logic next_wd_decel;

  always_comb begin
    wd_level = fn_on(ddif_pkg::FN_WATCHDOG);
    wd_armed = (wd_level || fn_off(ddif_pkg::FN_WATCHDOG)) &&
      (i_watchdog_timeout_setting != 15'h0000);
  end
  assign wd_edge = wd_level && !wd_prev;
  assign ws_coast = o_wd_coast;

  always_comb begin
    next_wd_state = wd_state;
    next_wd_pre = wd_pre;
    next_wd_cnt = wd_cnt;
    next_wd_fault = o_watchdog_fault;
    next_wd_coast = o_wd_coast;
    next_wd_decel = o_wd_decel;
    case (wd_state)
      WD_WATCH: begin
        if (!wd_armed || wd_edge) begin
          next_wd_pre = 25'h0000000;
          next_wd_cnt = 15'h0000;
        end else if (wd_cnt >= i_watchdog_timeout_setting) begin
          next_wd_pre = 25'h0000000;
          if (i_watchdog_stop_select) begin
            next_wd_state = WD_DECEL;
            next_wd_decel = 1'b1;
          end else begin
            next_wd_state = WD_TRIP;
            next_wd_fault = 1'b1;
            next_wd_coast = 1'b1;
          end
        end else if (wd_pre >= 25'(WD_TICK - 1)) begin
          next_wd_pre = 25'h0000000;
          if (wd_cnt != ddif_pkg::WD_TIME_MAX) begin
            next_wd_cnt = wd_cnt + 15'h0001;
          end
        end else begin
          next_wd_pre = wd_pre + 25'h0000001;
        end
      end
      WD_DECEL: begin
        if (i_stopped) begin
          next_wd_state = WD_TRIP;
          next_wd_fault = 1'b1;
          next_wd_decel = 1'b0;
        end
      end
      WD_TRIP: begin
        if (clear_req) begin
          next_wd_state = WD_WATCH;
          next_wd_fault = 1'b0;
          next_wd_coast = 1'b0;
          next_wd_cnt = 15'h0000;
        end
      end
      default: begin
        next_wd_state = WD_WATCH;
      end
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      wd_state <= WD_WATCH;
      wd_pre <= 25'h0000000;
      wd_cnt <= 15'h0000;
      wd_prev <= 1'b0;
      o_watchdog_fault <= 1'b0;
      o_wd_coast <= 1'b0;
      o_wd_decel <= 1'b0;
    end else begin
      wd_state <= next_wd_state;
      wd_pre <= next_wd_pre;
      wd_cnt <= next_wd_cnt;
      wd_prev <= wd_level;
      o_watchdog_fault <= next_wd_fault;
      o_wd_coast <= next_wd_coast;
      o_wd_decel <= next_wd_decel;
    end
  end

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  sequence s_decel_wait;
    wd_state == WD_DECEL && o_wd_decel;
  endsequence
  sequence s_trip_done;
    o_watchdog_fault && !o_wd_decel && !o_wd_coast;
  endsequence

  a_sum_source: assert property (src_on &&
    i_freq_source_combine_select == ddif_pkg::COMBINE_SUM |=> o_freq_sum_main)
    else $error("sum source not selected");
  a_fire_mode: assert property (i_fire_mode_enable && fire_mode_on
    |=> o_fire_mode) else $error("fire mode not entered");
  a_ptc_open: assert property ((i_running && ptc_no_on) ##1 !clear_req
    |-> o_motor_overtemp_fault [*2]) else $error("open ptc trip missing");
  a_ptc_closed: assert property (i_running && ptc_nc_off
    |=> o_motor_overtemp_fault) else $error("closed ptc trip missing");
  a_dir_reverse: assert property (o_reverse == $past(dir_on))
    else $error("direction wrong");
  a_ramp_select: assert property (o_ramp_set == $past(ramp_code))
    else $error("ramp set wrong");
  a_speed_stage: assert property (speed_code != ddif_pkg::SPEED_NONE
    |=> o_speed_stage == $past(speed_code) + 4'h1) else $error("speed stage wrong");
  a_speed_none: assert property (speed_code == ddif_pkg::SPEED_NONE
    |=> o_speed_stage == 4'h0) else $error("speed none wrong");
  a_wd_disabled: assert property (i_watchdog_timeout_setting == 15'h0000 &&
    wd_state == WD_WATCH |=> !o_watchdog_fault && wd_cnt == 15'h0000)
    else $error("disabled watchdog counted");
  a_wd_restart: assert property (wd_state == WD_WATCH && wd_edge
    |=> wd_cnt == 15'h0000 && wd_pre == 25'h0000000) else $error("watchdog not restarted");
  a_wd_coast: assert property (wd_state == WD_WATCH && wd_armed && !wd_edge &&
    wd_cnt >= i_watchdog_timeout_setting && !i_watchdog_stop_select
    |=> o_watchdog_fault && o_wd_coast ##1 o_coast_stop) else $error("coast trip missing");
  a_wd_decel: assert property (s_decel_wait ##0 i_stopped |=> s_trip_done)
    else $error("decel trip order wrong");
  a_coast_prio: assert property (coast_in |=> o_coast_stop && !o_jog_request)
    else $error("coast stop not dominant");
  a_ext_trip: assert property (ext_in
    |=> o_external_trip && o_external_fault_indication) else $error("external trip missing");
endmodule // ddif_top

// file: rtl/ddif_pkg.sv
// Constants shared by the digital input function block.
package ddif_pkg;
  localparam int NUM_DI = 8;
  localparam int CLK_MHZ = 250;
  // Watchdog setting unit is 0.1 s; filter sample period is 1 ms.
  localparam int WD_UNIT_US = 100000;
  localparam int WD_TICK_CYC = CLK_MHZ * WD_UNIT_US;
  localparam int FILT_SAMPLE_US = 1000;
  localparam int FILT_TICK_CYC = CLK_MHZ * FILT_SAMPLE_US;
  localparam logic [6:0] FILT_COUNT_RST = 7'h0A;
  localparam logic [14:0] WD_TIME_RST = 15'h0064;
  localparam logic [14:0] WD_TIME_MAX = 15'h7530;
  localparam logic [2:0] COMBINE_SWAP = 3'h2;
  localparam logic [2:0] COMBINE_SUM = 3'h3;
  localparam logic [2:0] APP_1 = 3'h1;
  localparam logic [2:0] APP_2 = 3'h2;
  localparam logic [2:0] APP_4 = 3'h4;
  localparam logic [7:0] FN_SPEED1 = 8'h03;
  localparam logic [7:0] FN_SPEED2 = 8'h04;
  localparam logic [7:0] FN_SPEED3 = 8'h05;
  localparam logic [7:0] FN_SPEED4 = 8'h06;
  localparam logic [7:0] FN_RESET = 8'h07;
  localparam logic [7:0] FN_COAST = 8'h08;
  localparam logic [7:0] FN_EXT_TRIP = 8'h09;
  localparam logic [7:0] FN_RAMP_LO = 8'h12;
  localparam logic [7:0] FN_SRC_SWITCH = 8'h15;
  localparam logic [7:0] FN_FIRE_PRESS = 8'h20;
  localparam logic [7:0] FN_FIRE_MODE = 8'h21;
  localparam logic [7:0] FN_RAMP_HI = 8'h22;
  localparam logic [7:0] FN_PTC_NO = 8'h25;
  localparam logic [7:0] FN_PTC_NC = 8'h26;
  localparam logic [7:0] FN_HIGH_FREQ = 8'h30;
  localparam logic [7:0] FN_JOG = 8'h34;
  localparam logic [7:0] FN_WATCHDOG = 8'h35;
  localparam logic [7:0] FN_FREQ_RESET = 8'h36;
  localparam logic [7:0] FN_MAN_AUTO = 8'h37;
  localparam logic [7:0] FN_MANUAL = 8'h38;
  localparam logic [7:0] FN_AUTO = 8'h39;
  localparam logic [7:0] FN_DIRECTION = 8'h3A;
  localparam logic [3:0] SPEED_NONE = 4'hF;
endpackage

// file: rtl/ddif_in_filt.sv
// One terminal's debounce filter: a new level must persist for N samples.
`timescale 1ns/1ps
module ddif_in_filt (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_tick,
  input wire logic [6:0] i_count,
  input wire logic i_raw,
  output logic o_level
);
  logic [6:0] run;
  logic [6:0] next_run;
  logic next_level;
  logic [6:0] limit;

  // A zero count acts as one: a change is accepted on its first differing sample.
  assign limit = (i_count == 7'h00) ? 7'h01 : i_count;

  always_comb begin
    next_run = run;
    next_level = o_level;
    if (i_tick) begin
      if (i_raw == o_level) begin
        next_run = 7'h00;
      end else if (run + 7'h01 >= limit) begin
        next_level = i_raw;
        next_run = 7'h00;
      end else begin
        next_run = run + 7'h01;
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      run <= 7'h00;
      o_level <= 1'b0;
    end else begin
      run <= next_run;
      o_level <= next_level;
    end
  end
endmodule // ddif_in_filt

// file: bench/ddif_term_model.sv
// Terminal-side model: switch contacts plus a controller that pulses the watchdog input.
`timescale 1ns/1ps
module ddif_term_model (
  input wire logic i_mclk,
  input wire logic [7:0] i_level,
  input wire logic i_pulse_en,
  input wire logic [7:0] i_pulse_period,
  output logic [7:0] o_terminal
);
  logic [7:0] phase;

  initial phase = 8'h00;

  // The phase runs only while pulsing, so a stopped controller leaves the line quiet.
  always @(negedge i_mclk) begin
    if (!i_pulse_en || (phase + 8'h01) >= i_pulse_period) begin
      phase <= 8'h00;
    end else begin
      phase <= phase + 8'h01;
    end
  end

  // Six clocks high spans three filter ticks, and the period stays under the timeout.
  assign o_terminal = {i_level[7] | (i_pulse_en && phase < 8'h06), i_level[6:0]};
endmodule // ddif_term_model

// file: bench/ddif_top_tb.sv
// Self-checking bench for the digital input function block.
`timescale 1ns/1ps
module ddif_top_tb;
  localparam int S_SUM = 3, S_SEC = 4, S_FPS = 5, S_OT = 7, S_HF = 8, S_JOG = 9, S_REV = 10;
  localparam int S_WDF = 11, S_WDC = 12, S_WDD = 13, S_MAS = 15, S_MAN = 16, S_AUT = 17;
  localparam int S_CST = 18, S_EXI = 20;
  logic i_mclk = 1'b0;
  logic i_rst = 1'b1;
  logic [7:0] lvl = 8'h00;
  logic [63:0] func = 64'h0;
  logic [6:0] fcnt = 7'h01;
  logic pol_c = 1'b0, pol_e = 1'b0, pid = 1'b0, fire = 1'b0, run = 1'b0, stp = 1'b0;
  logic frst = 1'b0, wdsel = 1'b0, pen = 1'b0;
  logic [2:0] comb = 3'h0, app = 3'h0;
  logic [14:0] wdset = 15'h0000;
  logic [7:0] pper = 8'h0C;
  logic [7:0] term, diag;
  logic [3:0] stage;
  logic [1:0] ramp;
  logic [17:0] flags;
  int fails = 0, checks_done = 0, cyc = 0;
  int q_id[$];
  logic [7:0] q_exp[$];
  string nm [21] = '{"diag", "stage", "ramp", "sum", "sec", "fps", "fire", "overtemp", "hf",
    "jog", "rev", "wd_fault", "wd_coast", "wd_decel", "freq_reset", "man_auto", "manual",
    "auto", "coast", "ext_trip", "ext_ind"};

  initial forever #2 i_mclk = ~i_mclk;

  ddif_term_model u_model (.i_mclk(i_mclk), .i_level(lvl), .i_pulse_en(pen),
    .i_pulse_period(pper), .o_terminal(term));

  ddif_top #(.WD_TICK(4), .FILT_TICK(2)) u_dut (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_multifunction_input_n(term), .i_func_sel(func),
    .i_input_filter_count(fcnt), .i_coast_stop_polarity(pol_c),
    .i_ext_coast_stop_polarity(pol_e), .i_freq_source_combine_select(comb),
    .i_app_select(app), .i_pid_active(pid), .i_fire_mode_enable(fire), .i_running(run),
    .i_stopped(stp), .i_fault_reset(frst), .i_watchdog_timeout_setting(wdset),
    .i_watchdog_stop_select(wdsel), .o_input_diag_view(diag), .o_freq_sum_main(flags[0]),
    .o_freq_use_secondary(flags[1]), .o_fire_pressure_setpoint_sel(flags[2]),
    .o_fire_mode(flags[3]), .o_motor_overtemp_fault(flags[4]), .o_high_freq_mode(flags[5]),
    .o_jog_request(flags[6]), .o_reverse(flags[7]), .o_watchdog_fault(flags[8]),
    .o_wd_coast(flags[9]), .o_wd_decel(flags[10]), .o_freq_reset_load(flags[11]),
    .o_manual_auto_switch(flags[12]), .o_manual_run(flags[13]), .o_auto_run(flags[14]),
    .o_ramp_set(ramp), .o_speed_stage(stage), .o_coast_stop(flags[15]),
    .o_external_trip(flags[16]), .o_external_fault_indication(flags[17]));

  function automatic logic [7:0] obs(input int id);
    case (id)
      0: obs = diag;
      1: obs = {4'h0, stage};
      2: obs = {6'h00, ramp};
      default: obs = {7'h00, flags[id - 3]};
    endcase
  endfunction

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude();
    if (fails == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic note(input int id, input logic [7:0] exp);
    q_id.push_back(id);
    q_exp.push_back(exp);
  endtask

  task automatic settle(input int n);
    repeat (n) @(negedge i_mclk);
  endtask

  task automatic put(input int t, input logic [7:0] code);
    func[8 * t +: 8] = code;
  endtask

  task automatic clr();
    frst = 1'b1;
    settle(2);
    frst = 1'b0;
    settle(3);
  endtask

  // Polls the design's own flag under a bound; the later note catches a miss.
  task automatic wait_for(input int id, input int lim);
    logic [7:0] v;
    int n;
    n = 0;
    v = obs(id);
    while (v[0] !== 1'b1 && n < lim) begin
      @(negedge i_mclk);
      v = obs(id);
      n++;
    end
  endtask

  // The watcher takes the oldest note once the driver has parked on a falling edge.
  initial begin
    forever begin
      wait (q_id.size() != 0);
      check(nm[q_id[0]], obs(q_id[0]), q_exp[0]);
      void'(q_id.pop_front());
      void'(q_exp.pop_front());
    end
  end

  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 8000) begin
      fails++;
      conclude();
    end
  end

  initial begin
    logic [7:0] r;
    logic [7:0] codes [6];
    int ids [6];
    int i;
    codes = '{ddif_pkg::FN_SRC_SWITCH, ddif_pkg::FN_FIRE_PRESS, ddif_pkg::FN_FIRE_MODE,
      ddif_pkg::FN_HIGH_FREQ, ddif_pkg::FN_FREQ_RESET, ddif_pkg::FN_EXT_TRIP};
    ids = '{3, 5, 6, 8, 14, 19};
    r = 8'h24;
    settle(5);
    i_rst = 1'b0;
    settle(1);
    note(0, 8'h00);
    put(0, ddif_pkg::FN_SPEED1);
    put(1, ddif_pkg::FN_SPEED2);
    put(2, ddif_pkg::FN_SPEED3);
    put(3, ddif_pkg::FN_SPEED4);
    put(4, ddif_pkg::FN_COAST);
    put(5, ddif_pkg::FN_DIRECTION);
    put(6, ddif_pkg::FN_JOG);
    lvl[4] = 1'b1;
    for (i = 0; i < 8; i++) begin
      r = lfsr(r);
      lvl[3:0] = (i == 0) ? 4'hF : r[3:0];
      settle(12);
      note(1, (lvl[3:0] == 4'hF) ? 8'h00 : {4'h0, lvl[3:0]} + 8'h01);
      note(0, {lvl[7:5], ~lvl[4], lvl[3:0]});
    end
    app = 3'h1;
    lvl[6:5] = 2'b11;
    settle(12);
    note(S_JOG, 8'h01);
    note(S_REV, 8'h01);
    lvl[5] = 1'b0;
    settle(12);
    note(S_REV, 8'h00);
    lvl[4] = 1'b0;
    settle(12);
    note(S_CST, 8'h01);
    note(S_JOG, 8'h00);
    pol_c = 1'b1;
    settle(4);
    note(S_CST, 8'h00);
    lvl[4] = 1'b1;
    settle(12);
    note(S_CST, 8'h01);
    pol_c = 1'b0;
    lvl[6] = 1'b0;
    comb = 3'h3;
    pid = 1'b1;
    fire = 1'b1;
    app = 3'h4;
    pol_e = 1'b1;
    for (i = 0; i < 6; i++) begin
      put(7, codes[i]);
      lvl[7] = 1'b1;
      settle(12);
      note(ids[i], 8'h01);
      lvl[7] = 1'b0;
      settle(12);
      note(ids[i], 8'h00);
    end
    note(S_EXI, 8'h01);
    clr();
    note(S_EXI, 8'h00);
    put(7, ddif_pkg::FN_SRC_SWITCH);
    comb = 3'h2;
    lvl[7] = 1'b1;
    settle(12);
    note(S_SEC, 8'h01);
    note(S_SUM, 8'h00);
    put(7, ddif_pkg::FN_PTC_NO);
    run = 1'b1;
    settle(4);
    note(S_OT, 8'h01);
    lvl[7] = 1'b0;
    settle(12);
    note(S_OT, 8'h01);
    put(6, ddif_pkg::FN_RESET);
    lvl[6] = 1'b1;
    settle(6);
    lvl[6] = 1'b0;
    settle(6);
    note(S_OT, 8'h00);
    run = 1'b0;
    put(7, ddif_pkg::FN_PTC_NC);
    settle(4);
    note(S_OT, 8'h00);
    run = 1'b1;
    settle(4);
    note(S_OT, 8'h01);
    lvl[7] = 1'b1;
    settle(12);
    clr();
    note(S_OT, 8'h00);
    lvl[7] = 1'b0;
    put(0, ddif_pkg::FN_RAMP_LO);
    put(1, ddif_pkg::FN_RAMP_HI);
    for (i = 0; i < 4; i++) begin
      lvl[1:0] = i[1:0];
      settle(12);
      note(2, i[7:0]);
    end
    app = 3'h2;
    put(0, ddif_pkg::FN_MAN_AUTO);
    put(1, ddif_pkg::FN_MANUAL);
    put(2, ddif_pkg::FN_AUTO);
    lvl[2:0] = 3'b011;
    settle(12);
    note(S_MAS, 8'h01);
    note(S_MAN, 8'h01);
    lvl[2:0] = 3'b101;
    settle(12);
    note(S_MAN, 8'h00);
    note(S_AUT, 8'h01);
    lvl[2:0] = 3'b100;
    settle(12);
    note(S_AUT, 8'h00);
    fcnt = 7'h03;
    put(0, ddif_pkg::FN_HIGH_FREQ);
    lvl[0] = 1'b0;
    settle(12);
    lvl[0] = 1'b1;
    settle(2);
    lvl[0] = 1'b0;
    settle(20);
    note(S_HF, 8'h00);
    lvl[0] = 1'b1;
    settle(20);
    note(S_HF, 8'h01);
    fcnt = 7'h01;
    put(7, ddif_pkg::FN_WATCHDOG);
    wdset = 15'h0005;
    pen = 1'b1;
    settle(100);
    note(S_WDF, 8'h00);
    pen = 1'b0;
    wait_for(S_WDF, 60);
    note(S_WDF, 8'h01);
    note(S_WDC, 8'h01);
    settle(2);
    note(S_CST, 8'h01);
    pen = 1'b1;
    clr();
    note(S_WDF, 8'h00);
    note(S_CST, 8'h00);
    wdsel = 1'b1;
    pen = 1'b0;
    wait_for(S_WDD, 60);
    settle(10);
    note(S_WDD, 8'h01);
    note(S_WDF, 8'h00);
    stp = 1'b1;
    settle(3);
    note(S_WDF, 8'h01);
    note(S_WDD, 8'h00);
    note(S_WDC, 8'h00);
    pen = 1'b1;
    stp = 1'b0;
    clr();
    note(S_WDF, 8'h00);
    wdset = 15'h0000;
    pen = 1'b0;
    settle(100);
    note(S_WDF, 8'h00);
    settle(2);
    conclude();
  end
endmodule // ddif_top_tb
